// [prcctl_decode.sv]
`default_nettype none

// Turns a twelve-row column image into a six-bit character: zone in the top two bits,
// digit row in the low four. Row 8 with a digit row from 1 to 7 adds eight to it.
module prcctl_decode (
    input wire logic [prcctl_pkg::COL_W-1:0] col, // Column image, bit 11 is row 12.
    output logic [prcctl_pkg::CHAR_W-1:0] code // Decoded character.
);
    logic [1:0] zone; // Zone part.
    logic [3:0] digit; // Digit part.
    logic found; // A digit row from 1 to 7 was seen.

    // Lowest punched digit row wins, so a mispunch still yields one defined code.
    always_comb
    begin
        zone = prcctl_pkg::ZONE_NONE;
        digit = 4'h0;
        found = 1'b0;
        for (int n = 1; n <= 7; n++)
        begin
            if (col[prcctl_pkg::ROW0_BIT - n] && !found)
            begin
                digit = 4'(n);
                found = 1'b1;
            end
        end
        // Row 8 alone is digit eight; with a digit row from 1 to 7 it adds eight.
        if (col[prcctl_pkg::ROW8_BIT])
        begin
            digit = digit + prcctl_pkg::DIGIT_EIGHT;
        end
        else if (col[0] && !found)
        begin
            digit = 4'h9;
        end
        // Zone rows: 12 over 11 over 0; a lone 0 punch is a digit.
        if (col[prcctl_pkg::ROW12_BIT])
        begin
            zone = prcctl_pkg::ZONE_TWELVE;
        end
        else if (col[prcctl_pkg::ROW11_BIT])
        begin
            zone = prcctl_pkg::ZONE_ELEVEN;
        end
        else if (col[prcctl_pkg::ROW0_BIT] && digit != 4'h0)
        begin
            zone = prcctl_pkg::ZONE_ZERO;
        end
        else if (col[prcctl_pkg::ROW0_BIT])
        begin
            digit = prcctl_pkg::DIGIT_ZERO;
        end
        code = {zone, digit};
    end
endmodule // prcctl_decode

`default_nettype wire

// [prcctl_fifo.sv]
`default_nettype none

// Small first-in first-out buffer with valid and ready on both sides.
module prcctl_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 4
) (
    input wire logic clk, // Clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic in_valid, // Writer offers a word.
    output logic in_ready, // Buffer has room.
    input wire logic [W-1:0] in_data, // Word offered.
    output logic out_valid, // Buffer holds a word.
    input wire logic out_ready, // Reader takes the word.
    output logic [W-1:0] out_data // Oldest word.
);
    localparam int AW = $clog2(DEPTH); // Address width.

    // Storage and pointers; an extra pointer bit tells full from empty.
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } prcctl_fifo_state_type;

    prcctl_fifo_state_type s_q; // Present state.
    prcctl_fifo_state_type s_d; // Next state.
    logic do_wr; // A word enters this cycle.
    logic do_rd; // A word leaves this cycle.

    // Full when pointers differ only in the top bit; empty when equal.
    always_comb
    begin
        in_ready = (s_q.wr ^ s_q.rd) != {1'b1, {AW{1'b0}}};
        out_valid = s_q.wr != s_q.rd;
        out_data = s_q.mem[s_q.rd[AW-1:0]];
        do_wr = in_valid && in_ready;
        do_rd = out_valid && out_ready;
        s_d = s_q;
        if (do_wr)
        begin
            s_d.mem[s_q.wr[AW-1:0]] = in_data;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (do_rd)
        begin
            s_d.rd = s_q.rd + 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule // prcctl_fifo

`default_nettype wire

// [prcctl_monitor.sv]
`default_nettype none

// Port-level checks tying each answer to its cause.
module prcctl_monitor #(
    parameter int COLUMN_LIMIT_CYCLES = 50 // Read deadline.
) (
    input wire logic CLK, // Clock.
    input wire logic RST_B, // Reset.
    input wire logic FETCH, // Fetch.
    input wire logic [2:0] OPCODE_HOLDER, // Opcode.
    input wire logic [11:0] INSTR_WORD, // Instruction.
    input wire logic EVENT_PULSE_1, // Pulse 1.
    input wire logic EVENT_PULSE_2, // Pulse 2.
    input wire logic EVENT_PULSE_3, // Pulse 3.
    input wire logic READER_NOT_READY_PIN, // Fault pin.
    input wire logic COLUMN_STROBE_PIN, // Strobe pin.
    input wire logic [11:0] COLUMN_ROWS_PIN, // Rows.
    input wire logic CARD_LEFT_PIN, // Card gone pin.
    input wire logic SKIP_REQUEST, // Skip.
    input wire logic WORKING_REGISTER_OR_EN, // Merge.
    input wire logic [11:0] WORKING_REGISTER_OR, // Data.
    input wire logic START_CARD, // Pick.
    input wire logic COLUMN_READY, // Column flag.
    input wire logic CARD_FINISHED, // Card flag.
    input wire logic READER_NOT_READY, // Status.
    input wire logic INTERRUPT_REQUEST, // Interrupt.
    input wire logic COLUMN_ACCEPT, // Room.
    input wire logic DATA_LOST, // Drop.
    input wire logic [6:0] COLUMNS_SEEN // Count.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic io_ok, col_dev, card_dev; // Decoded transfer fields.
    logic cmd_q; // A gated command was taken at the last edge.
    logic [19:0] hold_q; // Cycles the column flag has stood.
    assign io_ok = FETCH && OPCODE_HOLDER == prcctl_pkg::IOT_OPCODE;
    assign col_dev = io_ok && INSTR_WORD[8:3] == prcctl_pkg::DEV_COLUMN;
    assign card_dev = io_ok && INSTR_WORD[8:3] == prcctl_pkg::DEV_CARD;
    // Helper state; a drop restarts the wait count.
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            cmd_q <= 1'b0;
            hold_q <= 20'h00000;
        end
        else
        begin
            cmd_q <= (col_dev || card_dev)
                && |({EVENT_PULSE_3, EVENT_PULSE_2, EVENT_PULSE_1} & INSTR_WORD[2:0]);
            hold_q <= (COLUMN_READY && !DATA_LOST) ? hold_q + 20'h00001 : 20'h00000;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sequence s_col_read;
        col_dev && (EVENT_PULSE_2 && INSTR_WORD[1] || EVENT_PULSE_3 && INSTR_WORD[2]);
    endsequence
    sequence s_select;
        card_dev && EVENT_PULSE_2 && INSTR_WORD[1];
    endsequence
    sequence s_merged;
        WORKING_REGISTER_OR_EN && !COLUMN_READY;
    endsequence
    irq_flags_a: assert property (INTERRUPT_REQUEST == (COLUMN_READY || CARD_FINISHED))
        else $error("interrupt differs from flags");
    col_skip_a: assert property (col_dev && EVENT_PULSE_1 && INSTR_WORD[0] && COLUMN_READY
        |=> SKIP_REQUEST) else $error("no skip on column ready");
    col_read_a: assert property (s_col_read |=> s_merged)
        else $error("read did not merge or clear");
    card_skip_a: assert property (card_dev && EVENT_PULSE_1 && INSTR_WORD[0] && CARD_FINISHED
        |=> SKIP_REQUEST) else $error("no skip on card finished");
    nrdy_select_a: assert property (s_select ##0 READER_NOT_READY
        |=> !START_CARD && !SKIP_REQUEST) else $error("select taken while not ready");
    ready_select_a: assert property (s_select ##0 !READER_NOT_READY
        |=> SKIP_REQUEST && !CARD_FINISHED) else $error("select not answered");
    card_clear_a: assert property (card_dev && EVENT_PULSE_3 && INSTR_WORD[2]
        && CARD_FINISHED |=> !CARD_FINISHED) else $error("card flag not cleared");
    answer_cause_a: assert property (SKIP_REQUEST || WORKING_REGISTER_OR_EN || START_CARD
        |-> cmd_q) else $error("answer without a command");
    nrdy_follow_a: assert property ($stable(READER_NOT_READY_PIN) [*5]
        |-> READER_NOT_READY == READER_NOT_READY_PIN) else $error("status ignores pin");
    count_max_a: assert property (COLUMNS_SEEN <= 7'h50)
        else $error("more than eighty columns");
    wait_bound_a: assert property (hold_q <= COLUMN_LIMIT_CYCLES + 4)
        else $error("column held past deadline");
endmodule // prcctl_monitor

bind prcctl_top prcctl_monitor #(.COLUMN_LIMIT_CYCLES(COLUMN_LIMIT_CYCLES)) mon (
    .CLK, .RST_B, .FETCH, .OPCODE_HOLDER, .INSTR_WORD, .EVENT_PULSE_1, .EVENT_PULSE_2,
    .EVENT_PULSE_3, .READER_NOT_READY_PIN, .COLUMN_STROBE_PIN, .COLUMN_ROWS_PIN,
    .CARD_LEFT_PIN, .SKIP_REQUEST, .WORKING_REGISTER_OR_EN, .WORKING_REGISTER_OR,
    .START_CARD, .COLUMN_READY, .CARD_FINISHED, .READER_NOT_READY, .INTERRUPT_REQUEST,
    .COLUMN_ACCEPT, .DATA_LOST, .COLUMNS_SEEN);

`default_nettype wire

// [prcctl_pkg.sv]
`default_nettype none

// Shared constants for the punched card reader controller.
package prcctl_pkg;

    // Instruction fields and event pulse gate bits.
    localparam logic [2:0] IOT_OPCODE = 3'h6; // Input-output transfer opcode, octal 6.
    localparam logic [5:0] DEV_COLUMN = 6'h33; // Device select octal 63, column commands.
    localparam logic [5:0] DEV_CARD = 6'h37; // Device select octal 67, card commands.
    localparam int DEV_MSB = 8; // Top bit of the device select field.
    localparam int DEV_LSB = 3; // Bottom bit of the device select field.
    localparam int GATE_P1 = 0; // Instruction bit 11 gates event pulse 1.
    localparam int GATE_P2 = 1; // Instruction bit 10 gates event pulse 2.
    localparam int GATE_P3 = 2; // Instruction bit 9 gates event pulse 3.

    // Column layout: bit 11 is row 12, bit 10 row 11, bit 9 row 0, bit 9-n row n.
    localparam int COL_W = 12; // Rows on a card.
    localparam int CHAR_W = 6; // Width of a decoded character.
    localparam int ROW12_BIT = 11; // Position of row 12.
    localparam int ROW11_BIT = 10; // Position of row 11.
    localparam int ROW0_BIT = 9; // Position of row 0.
    localparam int ROW8_BIT = 1; // Position of row 8.
    localparam logic [1:0] ZONE_NONE = 2'h0; // No zone punch.
    localparam logic [1:0] ZONE_ZERO = 2'h1; // Zone punch in row 0.
    localparam logic [1:0] ZONE_ELEVEN = 2'h2; // Zone punch in row 11.
    localparam logic [1:0] ZONE_TWELVE = 2'h3; // Zone punch in row 12.
    localparam logic [3:0] DIGIT_ZERO = 4'hA; // Lone row 0 reads as digit ten.
    localparam logic [3:0] DIGIT_EIGHT = 4'h8; // Row 8 added to another digit.

    // Card geometry, buffering and synchronisers.
    localparam int COLUMNS_PER_CARD = 80; // Columns delivered per card.
    localparam int CNT_W = 7; // Width of the column counter.
    localparam int FIFO_DEPTH = 4; // Columns buffered between reader and flag.
    localparam int SYNC_STAGES = 3; // Flip-flops on each pin input.

    // Column read deadline.
    localparam real CLK_MHZ = 200.0; // Clock rate.
    localparam real COLUMN_LIMIT_MS = 1.4; // Deadline in milliseconds.
    localparam int COLUMN_LIMIT_CYCLES = int'($floor(COLUMN_LIMIT_MS * 1000.0 * CLK_MHZ));
    localparam int TIMER_W = 19; // Wide enough for the deadline count.

    // Reset values.
    localparam logic NRDY_RESET = 1'b1; // Reader counts as not ready until seen.
    localparam logic [2:0] NRDY_SYNC_RESET = 3'h7; // Synchroniser matches that value.

endpackage : prcctl_pkg

`default_nettype wire

// [prcctl_reader_model.sv]
`default_nettype none

// Reader: each pick senses all columns of one card, then the card leaves.
module prcctl_reader_model #(
    parameter int GAP = 30 // Idle cycles before each column.
) (
    input wire logic clk, // Clock.
    input wire logic start, // Pick request.
    input wire logic [11:0] tab [8], // Row images, repeating.
    output logic strobe, // Column sensed.
    output logic [11:0] rows, // Row image, punched is one.
    output logic card_left // Card gone.
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pick seen while a card moves is lost.
    initial
    begin
        strobe = 1'b0;
        rows = 12'hFFF;
        card_left = 1'b0;
        forever
        begin
            @(posedge clk);
            #1;
            if (start === 1'b1)
            begin
                for (int i = 0; i < prcctl_pkg::COLUMNS_PER_CARD; i++)
                begin
                    repeat (GAP) @(posedge clk);
                    #1 rows = tab[i % 8];
                    repeat (4) @(posedge clk);
                    #1 strobe = 1'b1;
                    repeat (6) @(posedge clk);
                    // Hold time is over, so a stale image must not pass for data.
                    #1 strobe = 1'b0;
                    rows = ~rows;
                end
                repeat (GAP) @(posedge clk);
                #1 card_left = 1'b1;
                repeat (4) @(posedge clk);
                #1 card_left = 1'b0;
            end
        end
    end
endmodule // prcctl_reader_model

`default_nettype wire

// [prcctl_top.sv]
// Behaviour
// - Commands only in fetch with opcode 6.
// - One select reads all 80 columns.
// - Punched hole reads one, blank zero.
// - Column ready raises flag and interrupt.
// - Card leaving raises finished flag, interrupt.
// - Not-ready status gathers faults, skip-testable.
// - Selects ignored while reader not ready.
// - Not-ready gives no interrupt, program-uncleared.
// - 6631 pulse 1 skips on column ready.
// - 6632 pulse 2 ORs character, clears flag.
// - 6634 pulse 3 ORs raw column, clears.
// - 6671 pulse 1 skips on card finished.
// - Each command completes within one instruction.
// - 6672 when ready skips, starts, clears finished; no pick while a card is still in the track.
// - 6674 pulse 3 clears card finished.
`default_nettype none

module prcctl_top #(
    parameter int COLUMN_LIMIT_CYCLES = prcctl_pkg::COLUMN_LIMIT_CYCLES
) (
    input wire logic CLK, // System clock, 200 MHz.
    input wire logic RST_B, // Asynchronous reset, active low.
    input wire logic FETCH, // Processor is in the fetch state.
    input wire logic [2:0] OPCODE_HOLDER, // Opcode held by the processor.
    input wire logic [11:0] INSTR_WORD, // Whole instruction, bit 0 is instruction bit 11.
    input wire logic EVENT_PULSE_1, // First event pulse, one cycle.
    input wire logic EVENT_PULSE_2, // Second event pulse, one cycle.
    input wire logic EVENT_PULSE_3, // Third event pulse, one cycle.
    input wire logic READER_NOT_READY_PIN, // Reader fault summary, asynchronous.
    input wire logic COLUMN_STROBE_PIN, // Rises when a column is sensed.
    input wire logic [11:0] COLUMN_ROWS_PIN, // Sensed rows, bit 11 is row 12.
    input wire logic CARD_LEFT_PIN, // Rises when the card leaves the station.
    output logic SKIP_REQUEST, // Advance the program counter, one cycle.
    output logic WORKING_REGISTER_OR_EN, // Merge data into the working register.
    output logic [11:0] WORKING_REGISTER_OR, // Data to be merged.
    output logic START_CARD, // Pick a card from the hopper, one cycle.
    output logic COLUMN_READY, // Column-ready flag.
    output logic CARD_FINISHED, // Card-finished flag.
    output logic READER_NOT_READY, // Synchronised not-ready status.
    output logic INTERRUPT_REQUEST, // Program interrupt request.
    output logic COLUMN_ACCEPT, // Column buffer has room.
    output logic DATA_LOST, // A column was dropped, one cycle.
    output logic [6:0] COLUMNS_SEEN // Columns sensed on the current card.
);

    // Whole controller state; the sync fields are pin synchronisers, index 0 first.
    typedef struct packed {
        logic [2:0] nrdy_s;
        logic [2:0] strb_s;
        logic [2:0] left_s;
        logic [2:0][11:0] rows_s;
        logic nrdy_q;
        logic strb_q;
        logic left_q;
        logic [11:0] col_q;
        logic col_ready_q;
        logic card_done_q;
        logic left_pend_q;
        logic moving_q;
        logic [prcctl_pkg::CNT_W-1:0] cnt_q;
        logic [prcctl_pkg::TIMER_W-1:0] wait_q;
        logic skip_q;
        logic start_q;
        logic acc_en_q;
        logic [11:0] acc_q;
        logic lost_q;
    } prcctl_state_type;

    prcctl_state_type s_q; // Present state.
    prcctl_state_type s_d; // Next state.
    logic [5:0] dev; // Device select field of the instruction.
    logic iot_now; // An input-output transfer instruction is under way.
    logic col_cmd; // It addresses the column device.
    logic card_cmd; // It addresses the card device.
    logic strb_edge; // A new column was sensed.
    logic left_edge; // The card just left the station.
    logic push_valid; // Column offered to the buffer.
    logic push_ready; // Buffer has room.
    logic pop_valid; // Buffer holds a column.
    logic pop_ready; // Holding register takes a column.
    logic [11:0] pop_data; // Oldest buffered column.
    logic [5:0] char_code; // Current column as a character.
    logic [prcctl_pkg::TIMER_W-1:0] limit; // Deadline count at register width.

    assign limit = prcctl_pkg::TIMER_W'(COLUMN_LIMIT_CYCLES - 1);

    // Columns waiting for software; COLUMN_ACCEPT shows the room left.
    prcctl_fifo #(
        .W(prcctl_pkg::COL_W),
        .DEPTH(prcctl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst_b(RST_B),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(s_q.rows_s[2]),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_data)
    );

    // Character form of the column held for software.
    prcctl_decode u_decode (
        .col(s_q.col_q),
        .code(char_code)
    );

    // Command decode and pin edges.
    always_comb
    begin
        dev = INSTR_WORD[prcctl_pkg::DEV_MSB:prcctl_pkg::DEV_LSB];
        iot_now = FETCH && (OPCODE_HOLDER == prcctl_pkg::IOT_OPCODE);
        col_cmd = iot_now && (dev == prcctl_pkg::DEV_COLUMN);
        card_cmd = iot_now && (dev == prcctl_pkg::DEV_CARD);
        // A pin change counts only once the second and third stages agree.
        strb_edge = (s_q.strb_s[1] == s_q.strb_s[2]) && s_q.strb_s[2] && !s_q.strb_q;
        left_edge = (s_q.left_s[1] == s_q.left_s[2]) && s_q.left_s[2] && !s_q.left_q;
        push_valid = strb_edge && s_q.moving_q
            && (s_q.cnt_q < prcctl_pkg::CNT_W'(prcctl_pkg::COLUMNS_PER_CARD));
        // Refill only between column instructions, so pulses 2 and 3 see one column.
        pop_ready = !s_q.col_ready_q && !col_cmd;
    end

    // Next-state logic for the whole controller.
    always_comb
    begin
        s_d = s_q;
        // Output pulses last a single cycle.
        s_d.skip_q = 1'b0;
        s_d.start_q = 1'b0;
        s_d.acc_en_q = 1'b0;
        s_d.lost_q = 1'b0;

        // Pin synchronisers; stage 0 feeds only stage 1.
        s_d.nrdy_s = {s_q.nrdy_s[1:0], READER_NOT_READY_PIN};
        s_d.strb_s = {s_q.strb_s[1:0], COLUMN_STROBE_PIN};
        s_d.left_s = {s_q.left_s[1:0], CARD_LEFT_PIN};
        s_d.rows_s = {s_q.rows_s[1:0], COLUMN_ROWS_PIN};

        if (s_q.nrdy_s[1] == s_q.nrdy_s[2])
        begin
            s_d.nrdy_q = s_q.nrdy_s[2];
        end
        if (s_q.strb_s[1] == s_q.strb_s[2])
        begin
            s_d.strb_q = s_q.strb_s[2];
        end
        if (s_q.left_s[1] == s_q.left_s[2])
        begin
            s_d.left_q = s_q.left_s[2];
        end

        // Count each sensed column; a full buffer drops it and reports it.
        if (push_valid)
        begin
            s_d.cnt_q = s_q.cnt_q + 1'b1;
            if (!push_ready)
            begin
                s_d.lost_q = 1'b1;
            end
        end

        // Card leaves: stop accepting columns and finish once the buffer drains.
        if (left_edge && s_q.moving_q)
        begin
            s_d.moving_q = 1'b0;
            s_d.left_pend_q = 1'b1;
        end

        if (s_q.col_ready_q)
        begin
            s_d.wait_q = s_q.wait_q + 1'b1;
            if (s_q.wait_q >= limit)
            begin
                s_d.col_ready_q = 1'b0;
                s_d.lost_q = 1'b1;
            end
        end

        // Column device commands; each gate bit enables one event pulse.
        if (col_cmd)
        begin
            if (EVENT_PULSE_1 && INSTR_WORD[prcctl_pkg::GATE_P1] && s_q.col_ready_q)
            begin
                s_d.skip_q = 1'b1;
            end
            // character into bits 6 to 11
            if (EVENT_PULSE_2 && INSTR_WORD[prcctl_pkg::GATE_P2])
            begin
                s_d.acc_q = {6'h00, char_code};
                s_d.acc_en_q = 1'b1;
                s_d.col_ready_q = 1'b0;
            end
            if (EVENT_PULSE_3 && INSTR_WORD[prcctl_pkg::GATE_P3])
            begin
                s_d.acc_q = s_q.col_q;
                s_d.acc_en_q = 1'b1;
                s_d.col_ready_q = 1'b0;
            end
        end

        // Card device commands.
        if (card_cmd)
        begin
            if (EVENT_PULSE_1 && INSTR_WORD[prcctl_pkg::GATE_P1] && s_q.card_done_q)
            begin
                s_d.skip_q = 1'b1;
            end
            if (EVENT_PULSE_2 && INSTR_WORD[prcctl_pkg::GATE_P2] && !s_q.nrdy_q)
            begin
                s_d.skip_q = 1'b1;
                s_d.card_done_q = 1'b0;
                // A card already in the track keeps running; no second pick.
                if (!s_q.moving_q && !s_q.left_pend_q)
                begin
                    s_d.start_q = 1'b1;
                    s_d.moving_q = 1'b1;
                    s_d.cnt_q = '0;
                end
            end
            if (EVENT_PULSE_3 && INSTR_WORD[prcctl_pkg::GATE_P3])
            begin
                s_d.card_done_q = 1'b0;
            end
        end

        if (pop_valid && pop_ready)
        begin
            s_d.col_q = pop_data;
            s_d.col_ready_q = 1'b1;
            s_d.wait_q = '0;
        end

        // card finished flag rises
        // After the clears, so an arriving finish wins.
        if (s_q.left_pend_q && !pop_valid)
        begin
            s_d.left_pend_q = 1'b0;
            s_d.card_done_q = 1'b1;
        end
    end

    // State register.
    // flags clear at reset
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            s_q <= '0;
            s_q.nrdy_s <= prcctl_pkg::NRDY_SYNC_RESET;
            s_q.nrdy_q <= prcctl_pkg::NRDY_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs; each answer is registered a cycle after its pulse.
    // answer within the instruction
    always_comb
    begin
        SKIP_REQUEST = s_q.skip_q;
        WORKING_REGISTER_OR_EN = s_q.acc_en_q;
        WORKING_REGISTER_OR = s_q.acc_q;
        START_CARD = s_q.start_q;
        COLUMN_READY = s_q.col_ready_q;
        CARD_FINISHED = s_q.card_done_q;
        READER_NOT_READY = s_q.nrdy_q;
        INTERRUPT_REQUEST = s_q.col_ready_q || s_q.card_done_q;
        COLUMN_ACCEPT = push_ready;
        DATA_LOST = s_q.lost_q;
        COLUMNS_SEEN = s_q.cnt_q;
    end

endmodule // prcctl_top

`default_nettype wire

// [tb.sv]
`default_nettype none

// The bench plays the processor; the model plays the reader.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 50; // Short read deadline keeps the run brief.
    logic clk = 1'b0, rst_b = 1'b0, fetch = 1'b0, nrdy_pin = 1'b0; // Driven inputs.
    logic [2:0] op = 3'h0, ev = 3'h0; // Opcode and event pulses.
    logic [11:0] iw = 12'h000; // Instruction word.
    logic strobe, card_left, skip, or_en, start, col_rdy, card_fin, nrdy, irq, accept, lost;
    logic [11:0] rows, or_data; // Row image and merged data.
    logic [6:0] seen; // Columns counted.
    logic sk, en, st; // Answers gathered over one instruction.
    logic [11:0] orv; // Data merged over one instruction.
    int num_errors = 0, checks_done = 0, cnt = 0;
    logic [11:0] tab [8] = '{12'h000, 12'h100, 12'h840, 12'h401,
                             12'h280, 12'h200, 12'h042, 12'h822};
    logic [5:0] chr [8] = '{6'h00, 6'h01, 6'h33, 6'h29, 6'h12, 6'h0A, 6'h0B, 6'h3C};
    prcctl_top #(.COLUMN_LIMIT_CYCLES(LIMIT)) uut (
        .CLK(clk), .RST_B(rst_b), .FETCH(fetch), .OPCODE_HOLDER(op), .INSTR_WORD(iw),
        .EVENT_PULSE_1(ev[0]), .EVENT_PULSE_2(ev[1]), .EVENT_PULSE_3(ev[2]),
        .READER_NOT_READY_PIN(nrdy_pin), .COLUMN_STROBE_PIN(strobe), .COLUMN_ROWS_PIN(rows),
        .CARD_LEFT_PIN(card_left), .SKIP_REQUEST(skip), .WORKING_REGISTER_OR_EN(or_en),
        .WORKING_REGISTER_OR(or_data), .START_CARD(start), .COLUMN_READY(col_rdy),
        .CARD_FINISHED(card_fin), .READER_NOT_READY(nrdy), .INTERRUPT_REQUEST(irq),
        .COLUMN_ACCEPT(accept), .DATA_LOST(lost), .COLUMNS_SEEN(seen));
    prcctl_reader_model #(.GAP(30)) reader (
        .clk(clk), .start(start), .tab(tab), .strobe(strobe), .rows(rows),
        .card_left(card_left));
    // Free-running 200 MHz clock.
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({11'h000, got}, {11'h000, exp});
    endtask
    // Waits, bounded, for column flag, card flag, drop or a full buffer.
    task automatic wait_hi(input int s, input int lim, output int n);
        n = 0;
        while (n < lim && (s == 0 ? col_rdy : s == 1 ? card_fin : s == 2 ? lost : !accept)
            !== 1'b1)
        begin
            tick;
            n++;
        end
        chk1(n < lim, 1'b1);
    endtask
    // One transfer instruction: three pulses in order, answers gathered.
    task automatic io_transfer_op(input logic [11:0] w, input logic f);
        fetch = f;
        op = w[11:9];
        iw = w;
        {sk, en, st, orv} = 15'h0000;
        for (int k = 0; k < 3; k++)
        begin
            tick;
            ev[k] = 1'b1;
            tick;
            ev[k] = 1'b0;
            sk |= skip;
            en |= or_en;
            st |= start;
            if (or_en === 1'b1)
            begin
                orv |= or_data;
            end
        end
        fetch = 1'b0;
        iw = 12'h000;
    endtask
    task automatic t_not_ready;
        nrdy_pin = 1'b1;
        repeat (6) tick;
        chk1(nrdy, 1'b1);
        io_transfer_op(12'hDBA, 1'b1);
        chk1(sk | st, 1'b0);
        io_transfer_op(12'hDBC, 1'b1);
        chk1(nrdy, 1'b1);
        chk1(irq, 1'b0);
        nrdy_pin = 1'b0;
        repeat (6) tick;
        chk1(nrdy, 1'b0);
    endtask
    task automatic t_refused;
        io_transfer_op(12'hDBA, 1'b0);
        chk1(st, 1'b0);
        io_transfer_op(12'hBBA, 1'b1);
        chk1(st, 1'b0);
        io_transfer_op(12'hDB2, 1'b1);
        chk1(sk | st, 1'b0);
        io_transfer_op(12'hDB8, 1'b1);
        chk1(sk | st, 1'b0);
        io_transfer_op(12'hDB9, 1'b1);
        chk1(sk, 1'b0);
    endtask
    // Full card, read alternately coded and raw, each with a skip test.
    task automatic t_card;
        io_transfer_op(12'hDBA, 1'b1);
        chk({10'h000, sk, st}, 12'h003);
        for (int i = 0; i < 80; i++)
        begin
            wait_hi(0, 200, cnt);
            chk1(irq, 1'b1);
            io_transfer_op(i[0] ? 12'hD9D : 12'hD9B, 1'b1);
            chk({10'h000, sk, en}, 12'h003);
            chk(orv, i[0] ? tab[i % 8] : {6'h00, chr[i % 8]});
            chk1(col_rdy, 1'b0);
        end
        wait_hi(1, 200, cnt);
        chk({5'h00, seen}, 12'h050);
        chk1(irq, 1'b1);
        io_transfer_op(12'hDB9, 1'b1);
        chk1(sk, 1'b1);
        io_transfer_op(12'hDBC, 1'b1);
        chk({10'h000, card_fin, irq}, 12'h000);
    endtask
    // Second card left unread: deadline drops, then the buffer fills.
    task automatic t_lost;
        io_transfer_op(12'hDBA, 1'b1);
        chk1(st, 1'b1);
        wait_hi(0, 200, cnt);
        wait_hi(2, LIMIT + 10, cnt);
        chk1(cnt >= LIMIT - 2, 1'b1);
        io_transfer_op(12'hDBA, 1'b1);
        chk({10'h000, sk, st}, 12'h002);
        wait_hi(3, 3000, cnt);
        wait_hi(1, 3000, cnt);
        chk({5'h00, seen}, 12'h050);
        chk1(irq, 1'b1);
    endtask
    task automatic end_sim;
        $display("Checks: %0d, errors: %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial
    begin
        repeat (16) @(posedge clk);
        #1 rst_b = 1'b1;
        chk({8'h00, col_rdy, card_fin, irq, nrdy}, 12'h001);
        repeat (6) tick;
        chk1(nrdy, 1'b0);
        t_not_ready;
        t_refused;
        t_card;
        t_lost;
        end_sim;
    end
    // The run needs about 6600 cycles; a hang beyond six times that fails.
    initial
    begin
        #200000;
        num_errors++;
        end_sim;
    end
endmodule // tb

`default_nettype wire
